//--- logic/tc8_cfg.svh
`ifndef TC8_CFG_SVH
`define TC8_CFG_SVH

// Register indices; the APB byte address of each register is four times its index.
`define IDX_CMP_A 10'h01C
`define IDX_CAP_B 10'h01D
`define IDX_CTRL 10'h01E
`define ADDR_CMP_A {`IDX_CMP_A, 2'b00}
`define ADDR_CAP_B {`IDX_CAP_B, 2'b00}
`define ADDR_CTRL {`IDX_CTRL, 2'b00}
// Control register field positions.
`define CTRL_MODE_BIT 0
`define CTRL_CLK_LO 1
`define CTRL_CLK_HI 3
`define CTRL_RUN_BIT 4
`define CTRL_AUTO_CAPTURE_ENABLE_BIT 6
// Reset values.
`define DATA_RESET 8'hFF
`define CTRL_RESET 8'h00
// Source clock code for the external pin, and the base divider exponent.
`define CLK_EXT 3'b111
`define DIV_EXP_BASE 13
`define PRESCALE_W 15

`endif

//--- logic/tc8_pkg.sv
package tc8_pkg;
    typedef enum logic [1:0] {
        MODE_TIMER = 2'b01,
        MODE_CAPTURE = 2'b10
    } mode_e;
    typedef logic [7:0] byte_t;
endpackage : tc8_pkg

//--- logic/tc8_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
`include "tc8_cfg.svh"
// Free-running divider; emits a one-cycle tick at the selected rate.
module tc8_prescaler
    import tc8_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [2:0] sel_i,
    input wire logic halve_i,
    output logic tick_o
);
    logic [`PRESCALE_W-1:0] div_r;
    logic [3:0] expo;
    logic [`PRESCALE_W-1:0] mask;

    always_comb begin
        expo = 4'(`DIV_EXP_BASE) - {1'b0, sel_i} + {3'b000, halve_i};
        mask = `PRESCALE_W'((32'h0000_0001 << expo) - 32'h0000_0001);
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || !run_i) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + `PRESCALE_W'(1);
        end
    end

    assign tick_o = run_i && ((div_r & mask) == mask);
endmodule : tc8_prescaler
`default_nettype wire

//--- logic/tc8_timer.sv
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "tc8_cfg.svh"
module tc8_timer
    import tc8_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic event_input_pin_i,
    input wire logic prescale_halve_select_i,
    input wire logic stop_entry_i,
    output logic timer_irq_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] compare_capture_a_r;
    logic [7:0] capture_b_r;
    logic run_control_r;
    logic auto_capture_enable_r;
    logic [2:0] source_clock_select_r;
    logic operating_mode_select_r;
    logic [7:0] count_r;
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_prev_r;
    logic irq_r;
    logic seen_fall_r;
    logic cap_hold_r;
    logic zero_after_match_r;
    logic [7:0] ctrl_rd;
    logic wr_en;
    logic rd_en;
    logic rd_a;
    logic pin_rise;
    logic pin_fall;
    logic tick;
    logic src_edge;
    logic capture_mode;
    logic ext_src;
    mode_e mode;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, unmapped addresses read zero with error.
    assign pready_o = 1'b1;
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && penable_i && !pwrite_i;
    assign rd_a = rd_en && (paddr_i == `ADDR_CMP_A);
    assign pslverr_o = psel_i && penable_i && (paddr_i != `ADDR_CMP_A) && (paddr_i != `ADDR_CAP_B)
        && (paddr_i != `ADDR_CTRL);
    assign ctrl_rd = {1'b0, auto_capture_enable_r, 1'b0, run_control_r, source_clock_select_r,
        operating_mode_select_r};

    always_comb begin
        case (paddr_i)
            `ADDR_CMP_A: prdata_o = {24'h0000_00, compare_capture_a_r};
            `ADDR_CAP_B: prdata_o = {24'h0000_00, capture_b_r};
            `ADDR_CTRL: prdata_o = {24'h0000_00, ctrl_rd};
            default: prdata_o = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            run_control_r <= 1'b0;
            auto_capture_enable_r <= 1'b0;
            source_clock_select_r <= 3'h0;
            operating_mode_select_r <= 1'b0;
        end else begin
            if (wr_en && paddr_i == `ADDR_CTRL) begin
                run_control_r <= pwdata_i[`CTRL_RUN_BIT];
                auto_capture_enable_r <= pwdata_i[`CTRL_AUTO_CAPTURE_ENABLE_BIT];
                source_clock_select_r <= pwdata_i[`CTRL_CLK_HI:`CTRL_CLK_LO];
                operating_mode_select_r <= pwdata_i[`CTRL_MODE_BIT];
            end
            if (stop_entry_i) begin
                run_control_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser; only the second stage feeds edge detection.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_prev_r <= 1'b0;
        end else begin
            pin_s1_r <= event_input_pin_i;
            pin_s2_r <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end

    assign pin_rise = run_control_r && pin_s2_r && !pin_prev_r;
    assign pin_fall = run_control_r && !pin_s2_r && pin_prev_r;

    tc8_prescaler u_prescaler (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .run_i(run_control_r),
        .sel_i(source_clock_select_r),
        .halve_i(prescale_halve_select_i),
        .tick_o(tick)
    );

    assign mode = operating_mode_select_r ? MODE_CAPTURE : MODE_TIMER;
    assign capture_mode = (mode == MODE_CAPTURE);
    assign ext_src = (source_clock_select_r == `CLK_EXT);
    // Counting source: pin rising edges on code 111, otherwise the prescaler tick.
    assign src_edge = ext_src ? pin_rise : tick;

    ////////////////////////////////////////////////////////////////////////////
    // Counter, match, capture and overflow.
    logic cmp_hit;
    logic event_mode;
    assign event_mode = !capture_mode && ext_src;
    // Timer: match on the counting edge once the count reaches A. Event: on the falling edge.
    assign cmp_hit = !capture_mode && (event_mode ? (pin_fall && count_r == compare_capture_a_r)
        : (tick && count_r == compare_capture_a_r));

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            count_r <= 8'h00;
            compare_capture_a_r <= `DATA_RESET;
            capture_b_r <= `DATA_RESET;
            irq_r <= 1'b0;
            seen_fall_r <= 1'b0;
            cap_hold_r <= 1'b0;
            zero_after_match_r <= 1'b0;
        end else if (!run_control_r) begin
            count_r <= 8'h00;
            irq_r <= 1'b0;
            seen_fall_r <= 1'b0;
            cap_hold_r <= 1'b0;
            zero_after_match_r <= 1'b0;
            // A is only written over APB while stopped; a write while running is dropped.
            if (wr_en && paddr_i == `ADDR_CMP_A) begin
                compare_capture_a_r <= pwdata_i[7:0];
            end
        end else begin
            irq_r <= 1'b0;
            if (rd_a) begin
                cap_hold_r <= 1'b0;
            end
            if (capture_mode) begin
                if (src_edge) begin
                    count_r <= count_r + 8'h01;
                end
                // While suspended only the counter runs; reading A re-arms capture.
                if (!cap_hold_r) begin
                    if (pin_rise) begin
                        compare_capture_a_r <= count_r;
                        count_r <= 8'h00;
                        irq_r <= 1'b1;
                    end else if (pin_fall) begin
                        capture_b_r <= count_r;
                        seen_fall_r <= 1'b1;
                    end else if (src_edge && count_r == 8'hFF) begin
                        compare_capture_a_r <= 8'hFF;
                        count_r <= 8'h00;
                        irq_r <= 1'b1;
                        cap_hold_r <= 1'b1;
                    end
                end
            end else begin
                if (cmp_hit) begin
                    count_r <= 8'h00;
                    irq_r <= 1'b1;
                    zero_after_match_r <= 1'b1;
                end else if (src_edge && !(event_mode && count_r == compare_capture_a_r)) begin
                    count_r <= count_r + 8'h01;
                    zero_after_match_r <= 1'b0;
                end
                if (auto_capture_enable_r && !zero_after_match_r && !cmp_hit) begin
                    capture_b_r <= count_r;
                end
            end
        end
    end

    assign timer_irq_o = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    property p_irq_pulse;
        @(posedge core_clk_i) disable iff (rst_i) timer_irq_o |=> !timer_irq_o;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");

    property p_stop_clears;
        @(posedge core_clk_i) disable iff (rst_i) stop_entry_i |=> !run_control_r;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stop entry left run set");

    property p_halt_zero;
        @(posedge core_clk_i) disable iff (rst_i) !run_control_r |=> count_r == 8'h00;
    endproperty
    a_halt_zero: assert property (p_halt_zero) else $error("counter not cleared when stopped");

    property p_match_clear;
        @(posedge core_clk_i) disable iff (rst_i) run_control_r && cmp_hit |=> count_r == 8'h00 && timer_irq_o;
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("match did not clear and interrupt");

    property p_no_zero_cap;
        @(posedge core_clk_i) disable iff (rst_i)
            run_control_r && cmp_hit ##1 run_control_r |=> $stable(capture_b_r) || capture_b_r != 8'h00;
    endproperty
    a_no_zero_cap: assert property (p_no_zero_cap) else $error("match zero captured into B");

    property p_fall_cap;
        @(posedge core_clk_i) disable iff (rst_i)
            run_control_r && capture_mode && !cap_hold_r && pin_fall |=> capture_b_r == $past(count_r);
    endproperty
    a_fall_cap: assert property (p_fall_cap) else $error("falling edge capture wrong");

    property p_rise_cap;
        @(posedge core_clk_i) disable iff (rst_i) run_control_r && capture_mode && !cap_hold_r && pin_rise
            |=> compare_capture_a_r == $past(count_r) && count_r == 8'h00 && timer_irq_o && $stable(capture_b_r);
    endproperty
    a_rise_cap: assert property (p_rise_cap) else $error("rising edge capture wrong");

    sequence s_overflow;
        run_control_r && capture_mode && !cap_hold_r && !pin_rise && !pin_fall && src_edge && count_r == 8'hFF;
    endsequence
    property p_overflow;
        @(posedge core_clk_i) disable iff (rst_i)
            s_overflow |=> compare_capture_a_r == 8'hFF && cap_hold_r && timer_irq_o;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow handling wrong");

    property p_hold_freeze;
        @(posedge core_clk_i) disable iff (rst_i)
            run_control_r && cap_hold_r && !rd_a ##1 run_control_r |-> !timer_irq_o;
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) else $error("capture active while suspended");

    ////////////////////////////////////////////////////////////////////////////
    // Counting and auto-capture checks for the timer and event counter modes, and a B check for capture mode.
    sequence s_event_rise;
        run_control_r && event_mode && pin_rise;
    endsequence
    property p_event_count;
        @(posedge core_clk_i) disable iff (rst_i)
            s_event_rise ##0 count_r != compare_capture_a_r
            |=> count_r == $past(count_r) + 8'h01 && !timer_irq_o;
    endproperty
    a_event_count: assert property (p_event_count) else $error("event edge not counted");

    property p_event_fall_match;
        @(posedge core_clk_i) disable iff (rst_i)
            run_control_r && event_mode && pin_fall && count_r == compare_capture_a_r
            |=> count_r == 8'h00 && timer_irq_o;
    endproperty
    a_event_fall_match: assert property (p_event_fall_match) else $error("event match missed");

    property p_timer_count;
        @(posedge core_clk_i) disable iff (rst_i)
            run_control_r && !capture_mode && !ext_src && tick && count_r != compare_capture_a_r
            |=> count_r == $past(count_r) + 8'h01;
    endproperty
    a_timer_count: assert property (p_timer_count) else $error("timer tick not counted");

    property p_count_idle;
        @(posedge core_clk_i) disable iff (rst_i)
            run_control_r && !capture_mode && !src_edge && !cmp_hit |=> $stable(count_r);
    endproperty
    a_count_idle: assert property (p_count_idle) else $error("counter moved without a source edge");

    property p_auto_copy;
        @(posedge core_clk_i) disable iff (rst_i)
            run_control_r && !capture_mode && auto_capture_enable_r && !zero_after_match_r && !cmp_hit
            |=> capture_b_r == $past(count_r);
    endproperty
    a_auto_copy: assert property (p_auto_copy) else $error("auto-capture missed the count");

    property p_no_auto_in_capture;
        @(posedge core_clk_i) disable iff (rst_i)
            run_control_r && capture_mode && !pin_fall |=> $stable(capture_b_r);
    endproperty
    a_no_auto_in_capture: assert property (p_no_auto_in_capture) else $error("B changed in capture mode");

    // Capture mode checks.
    sequence s_first_rise;
        run_control_r && capture_mode && !cap_hold_r && !seen_fall_r && pin_rise;
    endsequence
    property p_first_rise;
        @(posedge core_clk_i) disable iff (rst_i)
            s_first_rise |=> $stable(capture_b_r) && timer_irq_o && count_r == 8'h00;
    endproperty
    a_first_rise: assert property (p_first_rise) else $error("first rising edge handled wrong");

    property p_fall_keeps_count;
        @(posedge core_clk_i) disable iff (rst_i)
            run_control_r && capture_mode && !cap_hold_r && pin_fall
            |=> count_r == $past(count_r) || count_r == $past(count_r) + 8'h01;
    endproperty
    a_fall_keeps_count: assert property (p_fall_keeps_count) else $error("falling edge disturbed counter");

    property p_hold_counts;
        @(posedge core_clk_i) disable iff (rst_i)
            run_control_r && capture_mode && cap_hold_r && src_edge |=> count_r == $past(count_r) + 8'h01;
    endproperty
    a_hold_counts: assert property (p_hold_counts) else $error("counter stopped while suspended");

    // Reset values.
    property p_reset_values;
        @(posedge core_clk_i) rst_i |=> compare_capture_a_r == `DATA_RESET && capture_b_r == `DATA_RESET
            && ctrl_rd == `CTRL_RESET && !timer_irq_o;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");
endmodule : tc8_timer
`default_nettype wire

//--- test/tc8_pulse_src.sv
`timescale 1ns/100ps
`default_nettype none
// Pulse source on the timer input pin; it changes the pin only just after a clock edge.
module tc8_pulse_src (
    input wire logic core_clk_i,
    output logic pin_o
);
    initial pin_o = 1'b0;
    task automatic set_level(input logic v);
        @(posedge core_clk_i);
        pin_o <= v;
    endtask : set_level
    task automatic pulses(input int n, input int w);
        for (int i = 0; i < n; i++) begin
            set_level(1'b1);
            repeat (w) @(posedge core_clk_i);
            set_level(1'b0);
            repeat (w) @(posedge core_clk_i);
        end
    endtask : pulses
endmodule : tc8_pulse_src
`default_nettype wire

//--- test/timer_counter_8bit_capture_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "tc8_cfg.svh"
module timer_counter_8bit_capture_tb_top;
    import tc8_pkg::*;
    logic core_clk_i, pready, pslverr, pin, irq, e;
    logic rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic halve = 1'b0;
    logic stop = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, q;
    int err_total = 0, cmp_count = 0, irq_cnt = 0, cyc = 0, irq_cyc = 0, n0, c1;
    tc8_timer dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .event_input_pin_i(pin), .prescale_halve_select_i(halve),
        .stop_entry_i(stop), .timer_irq_o(irq));
    tc8_pulse_src src (.core_clk_i(core_clk_i), .pin_o(pin));
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
            irq_cyc <= cyc;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        @(posedge core_clk_i);
        while (pready !== 1'b1) begin
            @(posedge core_clk_i);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk_i);
    endtask : xfer
    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(name, exp, q);
    endtask : rd_chk
    task automatic irqs(input string name, input int exp, input int w);
        repeat (w) @(posedge core_clk_i);
        chk(name, exp, irq_cnt - n0);
    endtask : irqs
    task automatic wait_irq();
        int n;
        n = irq_cnt;
        for (int i = 0; i < 3000 && irq_cnt == n; i++) @(posedge core_clk_i);
        if (irq_cnt == n) begin
            err_total++;
            $display("BAD wait_irq expected an irq seen none");
        end
    endtask : wait_irq
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk("a", `ADDR_CMP_A, 32'h0000_00FF);
        rd_chk("b", `ADDR_CAP_B, 32'h0000_00FF);
        rd_chk("ctrl", `ADDR_CTRL, 32'h0000_0000);
        xfer(1'b0, 12'h010, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0, e});
        $display("t_reset done");
    endtask : t_reset
    task automatic t_capture();
        xfer(1'b1, `ADDR_CTRL, 32'h0000_000D);
        xfer(1'b1, `ADDR_CTRL, 32'h0000_001D);
        n0 = irq_cnt;
        src.set_level(1'b1);
        irqs("rise first irq", 1, 10);
        rd_chk("b kept", `ADDR_CAP_B, 32'h0000_00FF);
        xfer(1'b0, `ADDR_CMP_A, 32'h0000_0000);
        chk("a small", 32'h0000_0001, {31'h0, q <= 1});
        repeat (660) @(posedge core_clk_i);
        src.set_level(1'b0);
        repeat (380) @(posedge core_clk_i);
        src.set_level(1'b1);
        irqs("capture irq", 2, 10);
        xfer(1'b0, `ADDR_CAP_B, 32'h0000_0000);
        chk("b width", 32'h0000_0001, {31'h0, q >= 4 && q <= 6});
        xfer(1'b0, `ADDR_CMP_A, 32'h0000_0000);
        chk("a period", 32'h0000_0001, {31'h0, q >= 7 && q <= 9});
        irqs("overflow irq", 3, 33200);
        src.set_level(1'b0);
        repeat (300) @(posedge core_clk_i);
        src.set_level(1'b1);
        irqs("suspended", 3, 10);
        rd_chk("a ovf", `ADDR_CMP_A, 32'h0000_00FF);
        src.set_level(1'b0);
        repeat (300) @(posedge core_clk_i);
        src.set_level(1'b1);
        irqs("resumed", 4, 10);
        xfer(1'b1, `ADDR_CTRL, 32'h0000_000C);
        $display("t_capture done");
    endtask : t_capture
    task automatic t_timer(input logic h, input int per);
        halve <= h;
        xfer(1'b1, `ADDR_CMP_A, 32'h0000_0003);
        xfer(1'b1, `ADDR_CTRL, 32'h0000_005C);
        wait_irq();
        wait_irq();
        c1 = irq_cyc;
        rd_chk("b held", `ADDR_CAP_B, 32'h0000_0003);
        repeat (per * 3 / 8) @(posedge core_clk_i);
        rd_chk("b live", `ADDR_CAP_B, 32'h0000_0001);
        wait_irq();
        chk("period", per, irq_cyc - c1);
        stop <= 1'b1;
        @(posedge core_clk_i);
        stop <= 1'b0;
        rd_chk("run cleared", `ADDR_CTRL, 32'h0000_004C);
        n0 = irq_cnt;
        irqs("halted", 0, 1200);
        $display("t_timer done");
    endtask : t_timer
    task automatic t_event();
        halve <= 1'b0;
        src.set_level(1'b0);
        xfer(1'b1, `ADDR_CTRL, 32'h0000_000E);
        xfer(1'b1, `ADDR_CTRL, 32'h0000_005E);
        n0 = irq_cnt;
        src.pulses(2, 8);
        src.set_level(1'b1);
        irqs("no early irq", 0, 8);
        rd_chk("b events", `ADDR_CAP_B, 32'h0000_0003);
        src.set_level(1'b0);
        irqs("fall irq", 1, 8);
        src.pulses(3, 8);
        irqs("restart", 2, 8);
        $display("t_event done");
    endtask : t_event
    task automatic t_midreset();
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        rd_chk("a after reset", `ADDR_CMP_A, 32'h0000_00FF);
        rd_chk("b after reset", `ADDR_CAP_B, 32'h0000_00FF);
        rd_chk("ctrl after reset", `ADDR_CTRL, 32'h0000_0000);
        $display("t_midreset done");
    endtask : t_midreset
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        t_reset();
        t_capture();
        t_timer(1'b0, 512);
        t_timer(1'b1, 1024);
        t_event();
        t_midreset();
        tally_and_finish();
    end
    initial begin
        #(20 * 90000);
        err_total++;
        tally_and_finish();
    end
endmodule : timer_counter_8bit_capture_tb_top
`default_nettype wire
